//--- include/mux_pkg.sv
// constants shared by the four-line serial multiplexer
package mux_pkg;
	// ---------------------------------------------------------------
	// clocking and sizes
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int LINES = 4;
	localparam int SILO_DEPTH = 64;
	localparam logic [4:0] ALARM_COUNT = 5'h10;
	localparam int ENTRY_W = 11;
	// line rate in tenths of a baud, indexed by the rate code
	localparam int BAUD_X10 [0:14] = '{500, 750, 1100, 1345, 1500, 3000,
		6000, 12000, 18000, 20000, 24000, 36000, 48000, 72000, 96000};
	localparam logic [3:0] RATE_UNUSED = 4'hf;
	// ---------------------------------------------------------------
	// register indexes on the host port
	// ---------------------------------------------------------------
	localparam logic [1:0] IDX_CONTROL = 2'h0;
	localparam logic [1:0] IDX_SILO = 2'h1;
	localparam logic [1:0] IDX_HOLD = 2'h2;
	localparam logic [1:0] IDX_LINE_EN = 2'h3;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CF_RIE = 6;
	localparam int CF_RECEIVE_DONE_FLAG = 7;
	localparam int CF_SAE = 12;
	localparam int CF_SA = 13;
	localparam int CF_TIE = 14;
	localparam int CF_TRANSMITTER_READY_FLAG = 15;
	localparam int FS_LEN_LO = 3;
	localparam int FS_STOP = 5;
	localparam int FS_PAR_EN = 6;
	localparam int FS_PAR_ODD = 7;
	localparam int FS_RATE_LO = 8;
	localparam int FS_RX_EN = 12;
	localparam int SW_VALID = 15;
	localparam int SW_PERR = 12;
	localparam int VEC_TX_BIT = 2;
	localparam logic [15:0] FORMAT_RESET = 16'h0000;
	localparam logic [8:0] BASE_VECTOR = 9'h0c0;
	// ---------------------------------------------------------------
	// bit timing in oversample ticks
	// ---------------------------------------------------------------
	localparam logic [4:0] TICK_MID = 5'h07;
	localparam logic [4:0] TICK_LAST = 5'h0f;
	localparam logic [4:0] STOP_ONE_LAST = 5'h0f;
	localparam logic [4:0] STOP_1P5_LAST = 5'h17;
	localparam logic [4:0] STOP_TWO_LAST = 5'h1f;
endpackage

//--- hw/two_entry_buffer.sv
// two-entry valid/ready buffer between the line receivers and the silo
`timescale 1ns/100ps
module two_entry_buffer #(
	parameter int W = mux_pkg::ENTRY_W
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} buf_state_t;
	buf_state_t r_reg, r_next;
	logic push, pop;

	assign in_ready_o = r_reg.cnt != 2'h2;
	assign out_valid_o = r_reg.cnt != 2'h0;
	assign out_data_o = r_reg.mem[r_reg.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb
	begin
		r_next = r_reg;
		if (push)
		begin
			r_next.mem[r_reg.wp] = in_data_i;
			r_next.wp = ~r_reg.wp;
		end
		if (pop)
			r_next.rp = ~r_reg.rp;
		r_next.cnt = r_reg.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end
endmodule // two_entry_buffer

//--- hw/rate_tick.sv
// oversample tick divider for one line, rate chosen by a four-bit code
`timescale 1ns/100ps
module rate_tick #(
	parameter int CLK_HZ = mux_pkg::CLK_HZ
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] code_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tick_state_t;
	tick_state_t r_reg, r_next;
	logic [15:0] div_tab [0:14];

	genvar g;
	generate
		for (g = 0; g < 15; g++)
		begin : g_div
			localparam int DIV = CLK_HZ * 10 /
				(mux_pkg::OVERSAMPLE * mux_pkg::BAUD_X10[g]);
			assign div_tab[g] = 16'(DIV > 1 ? DIV - 1 : 0);
		end
	endgenerate

	assign tick_o = r_reg.tick;

	always_comb
	begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		// the unused code gives no tick, so the line simply stalls
		if (code_i != mux_pkg::RATE_UNUSED)
		begin
			if (r_reg.cnt >= div_tab[code_i])
			begin
				r_next.cnt = 16'h0000;
				r_next.tick = 1'b1;
			end
			else
				r_next.cnt = r_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end
endmodule // rate_tick

//--- hw/serial_mux.sv
// four-line serial multiplexer: format, silo, scanner and interrupts
`timescale 1ns/100ps
// Behaviour
// - two adjacent vectors; the second drives data bit 2 high
// - receive vector goes out before transmit when both pend
// - receive request at base vector from receive-done or silo alarm
// - transmit request at base plus 4 from ready flag and its enable
// - format bits 11:8 pick one of fifteen line rates; 1111 unused
// - one rate per line, shared by its receiver and transmitter
// - receiver sampling runs only while format bit 12 is one
// - format bits 4:3 pick five to eight data bits
// - unused upper data bits of received characters read zero
// - bit 5 picks one or two stop units; 1.5 with five bits
// - format bit 6 adds parity on transmit and checks it on receive
// - format bit 7 picks parity sense, ignored when bit 6 is zero
// - parity made and checked in hardware, never in buffer data
// - silo word bit 12 flags a parity failure with its character
// - receive-done is set while the silo holds any character
// - with both receive enables clear no receive interrupt occurs
// - receive enable alone interrupts whenever a character waits
// - both enables set interrupt only on the silo alarm
// - alarm sets after sixteen entries since the last silo read
// - any silo read clears the alarm and its entry count
// - ready flag only when a character can be taken; irq if enabled
// - a silo read returns the bottom entry and removes it
// - scanner serves the highest-numbered enabled line first
module serial_mux #(
	parameter int CLK_HZ = mux_pkg::CLK_HZ,
	parameter logic [8:0] BASE_VECTOR = mux_pkg::BASE_VECTOR
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] host_idx_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	output logic irq_req_o,
	input wire logic irq_ack_i,
	output logic [8:0] irq_vector_o,
	input wire logic [3:0] rx_line_i,
	output logic [3:0] tx_line_o
);
	// ---------------------------------------------------------------
	// types and state
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		tx_state_t;
	typedef struct packed {
		logic [3:0][15:0] fmt;
		logic [3:0] line_en;
		logic receive_irq_enable;
		logic alarm_irq_enable;
		logic transmit_irq_enable;
		logic sa;
		logic [4:0] alarm_cnt;
		logic transmitter_ready_flag;
		logic [1:0] svc;
		logic [3:0][7:0] hold;
		logic [3:0] hold_full;
		tx_state_t [3:0] tx_st;
		logic [3:0][4:0] tx_cnt;
		logic [3:0][2:0] tx_bit;
		logic [3:0][7:0] tx_sh;
		logic [3:0] tx_out;
		rx_state_t [3:0] rx_st;
		logic [3:0][4:0] rx_cnt;
		logic [3:0][2:0] rx_bit;
		logic [3:0][7:0] rx_sh;
		logic [3:0] rx_perr;
		logic [3:0] rxq_v;
		logic [3:0][8:0] rxq;
		logic [5:0] wp;
		logic [5:0] rp;
		logic [6:0] fill;
		logic [15:0] rdata;
		logic [8:0] vec;
	} mux_state_t;
	mux_state_t r_reg, r_next;
	logic [mux_pkg::ENTRY_W-1:0] silo_mem [mux_pkg::SILO_DEPTH];
	logic [3:0] tick;
	logic buf_in_ready, buf_out_valid, silo_push;
	logic [mux_pkg::ENTRY_W-1:0] buf_in_data, buf_out_data;
	logic [1:0] rx_sel;
	logic receive_done_flag, rx_irq, tx_irq;

	// highest set line wins; shared by the scanner and receive arbiter
	function automatic logic [1:0] top_line(input logic [3:0] v);
		logic [1:0] t;
		t = 2'h0;
		for (int k = 0; k < 4; k++)
			if (v[k])
				t = 2'(k);
		return t;
	endfunction

	// ---------------------------------------------------------------
	// per-line rate dividers
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < mux_pkg::LINES; g++)
		begin : g_line
			// one divider per line drives both directions
			rate_tick #(.CLK_HZ(CLK_HZ)) u_rate (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.code_i(r_reg.fmt[g][mux_pkg::FS_RATE_LO +: 4]),
				.tick_o(tick[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// receive path: lines to buffer to silo
	// ---------------------------------------------------------------
	assign rx_sel = top_line(r_reg.rxq_v);
	assign buf_in_data = {rx_sel, r_reg.rxq[rx_sel]};
	assign silo_push = buf_out_valid &&
		(r_reg.fill != 7'(mux_pkg::SILO_DEPTH));

	two_entry_buffer #(.W(mux_pkg::ENTRY_W)) u_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(|r_reg.rxq_v),
		.in_ready_o(buf_in_ready),
		.in_data_i(buf_in_data),
		.out_valid_o(buf_out_valid),
		.out_ready_i(silo_push),
		.out_data_o(buf_out_data)
	);

	assign receive_done_flag = r_reg.fill != 7'h00;
	// alarm mode masks per-character requests
	assign rx_irq = r_reg.receive_irq_enable && (r_reg.alarm_irq_enable ? r_reg.sa : receive_done_flag);
	assign tx_irq = r_reg.transmit_irq_enable && r_reg.transmitter_ready_flag;
	assign irq_req_o = rx_irq || tx_irq;
	assign host_rdata_o = r_reg.rdata;
	assign irq_vector_o = r_reg.vec;
	assign tx_line_o = r_reg.tx_out;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [15:0] f;
		logic [2:0] last_bit;
		logic [4:0] stop_last;
		logic [7:0] mask;
		logic rd_silo;
		logic [3:0] need;
		f = '0;
		last_bit = '0;
		stop_last = '0;
		mask = '0;
		need = '0;
		r_next = r_reg;
		rd_silo = host_rd_i && host_idx_i == mux_pkg::IDX_SILO;
		// a taken word frees its line; a new one below may refill it
		if (buf_in_ready && |r_reg.rxq_v)
			r_next.rxq_v[rx_sel] = 1'b0;
		for (int i = 0; i < mux_pkg::LINES; i++)
		begin
			f = r_reg.fmt[i];
			last_bit = {1'b0, f[mux_pkg::FS_LEN_LO +: 2]} + 3'h4;
			mask = 8'hff >> (2'h3 - f[mux_pkg::FS_LEN_LO +: 2]);
			if (!f[mux_pkg::FS_STOP])
				stop_last = mux_pkg::STOP_ONE_LAST;
			else if (f[mux_pkg::FS_LEN_LO +: 2] == 2'h0)
				stop_last = mux_pkg::STOP_1P5_LAST;
			else
				stop_last = mux_pkg::STOP_TWO_LAST;
			// receiver: idle when its enable is clear
			if (!f[mux_pkg::FS_RX_EN])
				r_next.rx_st[i] = RX_IDLE;
			else if (tick[i])
			begin
				r_next.rx_cnt[i] = r_reg.rx_cnt[i] + 5'h01;
				unique case (r_reg.rx_st[i])
					RX_IDLE:
						if (!rx_line_i[i])
						begin
							r_next.rx_st[i] = RX_START;
							r_next.rx_cnt[i] = 5'h00;
						end
					RX_START:
						if (r_reg.rx_cnt[i] == mux_pkg::TICK_MID)
						begin
							r_next.rx_st[i] = rx_line_i[i] ? RX_IDLE : RX_DATA;
							r_next.rx_cnt[i] = 5'h00;
							r_next.rx_bit[i] = 3'h0;
							r_next.rx_sh[i] = 8'h00;
							r_next.rx_perr[i] = 1'b0;
						end
					RX_DATA:
						if (r_reg.rx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.rx_cnt[i] = 5'h00;
							r_next.rx_sh[i][r_reg.rx_bit[i]] = rx_line_i[i];
							r_next.rx_bit[i] = r_reg.rx_bit[i] + 3'h1;
							if (r_reg.rx_bit[i] == last_bit)
								r_next.rx_st[i] = f[mux_pkg::FS_PAR_EN] ?
									RX_PAR : RX_STOP;
						end
					RX_PAR:
						if (r_reg.rx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.rx_cnt[i] = 5'h00;
							// parity bit checked here and then dropped
							r_next.rx_perr[i] = ^r_reg.rx_sh[i] ^ rx_line_i[i] ^
								f[mux_pkg::FS_PAR_ODD];
							r_next.rx_st[i] = RX_STOP;
						end
					RX_STOP:
						if (r_reg.rx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.rx_st[i] = RX_IDLE;
							r_next.rxq_v[i] = 1'b1;
							r_next.rxq[i] = {r_reg.rx_perr[i], r_reg.rx_sh[i]};
						end
					default:
						r_next.rx_st[i] = RX_IDLE;
				endcase
			end
			// transmitter
			if (tick[i])
			begin
				r_next.tx_cnt[i] = r_reg.tx_cnt[i] + 5'h01;
				unique case (r_reg.tx_st[i])
					TX_IDLE:
						if (r_reg.hold_full[i])
						begin
							r_next.tx_sh[i] = r_reg.hold[i] & mask;
							r_next.hold_full[i] = 1'b0;
							r_next.tx_st[i] = TX_START;
							r_next.tx_cnt[i] = 5'h00;
						end
					TX_START:
						if (r_reg.tx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.tx_st[i] = TX_DATA;
							r_next.tx_cnt[i] = 5'h00;
							r_next.tx_bit[i] = 3'h0;
						end
					TX_DATA:
						if (r_reg.tx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.tx_cnt[i] = 5'h00;
							r_next.tx_bit[i] = r_reg.tx_bit[i] + 3'h1;
							if (r_reg.tx_bit[i] == last_bit)
								r_next.tx_st[i] = f[mux_pkg::FS_PAR_EN] ?
									TX_PAR : TX_STOP;
						end
					TX_PAR:
						if (r_reg.tx_cnt[i] == mux_pkg::TICK_LAST)
						begin
							r_next.tx_cnt[i] = 5'h00;
							r_next.tx_st[i] = TX_STOP;
						end
					TX_STOP:
						if (r_reg.tx_cnt[i] == stop_last)
							r_next.tx_st[i] = TX_IDLE;
					default:
						r_next.tx_st[i] = TX_IDLE;
				endcase
			end
			unique case (r_next.tx_st[i])
				TX_START: r_next.tx_out[i] = 1'b0;
				TX_DATA: r_next.tx_out[i] = r_next.tx_sh[i][r_next.tx_bit[i]];
				TX_PAR: r_next.tx_out[i] = ^r_next.tx_sh[i] ^
					f[mux_pkg::FS_PAR_ODD];
				default: r_next.tx_out[i] = 1'b1;
			endcase
		end
		// scanner: offers one line whose holding register is empty
		need = r_reg.line_en & ~r_reg.hold_full;
		if (r_reg.transmitter_ready_flag && !r_reg.line_en[r_reg.svc])
			r_next.transmitter_ready_flag = 1'b0;
		else if (!r_reg.transmitter_ready_flag && |need)
		begin
			r_next.transmitter_ready_flag = 1'b1;
			r_next.svc = top_line(need);
		end
		// host writes
		if (host_wr_i)
		begin
			unique case (host_idx_i)
				mux_pkg::IDX_CONTROL:
				begin
					r_next.receive_irq_enable = host_wdata_i[mux_pkg::CF_RIE];
					r_next.alarm_irq_enable = host_wdata_i[mux_pkg::CF_SAE];
					r_next.transmit_irq_enable = host_wdata_i[mux_pkg::CF_TIE];
				end
				mux_pkg::IDX_SILO:
					r_next.fmt[host_wdata_i[1:0]] = host_wdata_i;
				mux_pkg::IDX_HOLD:
					if (r_reg.transmitter_ready_flag)
					begin
						r_next.hold[r_reg.svc] = host_wdata_i[7:0];
						r_next.hold_full[r_reg.svc] = 1'b1;
						r_next.transmitter_ready_flag = 1'b0;
					end
				mux_pkg::IDX_LINE_EN:
					r_next.line_en = host_wdata_i[3:0];
			endcase
		end
		// host reads
		r_next.rdata = 16'h0000;
		if (host_rd_i)
		begin
			unique case (host_idx_i)
				mux_pkg::IDX_CONTROL:
				begin
					r_next.rdata[mux_pkg::CF_RIE] = r_reg.receive_irq_enable;
					r_next.rdata[mux_pkg::CF_RECEIVE_DONE_FLAG] = receive_done_flag;
					r_next.rdata[9:8] = r_reg.svc;
					r_next.rdata[mux_pkg::CF_SAE] = r_reg.alarm_irq_enable;
					r_next.rdata[mux_pkg::CF_SA] = r_reg.sa;
					r_next.rdata[mux_pkg::CF_TIE] = r_reg.transmit_irq_enable;
					r_next.rdata[mux_pkg::CF_TRANSMITTER_READY_FLAG] = r_reg.transmitter_ready_flag;
				end
				mux_pkg::IDX_SILO:
					if (receive_done_flag)
					begin
						r_next.rdata[mux_pkg::SW_VALID] = 1'b1;
						r_next.rdata[mux_pkg::SW_PERR] = silo_mem[r_reg.rp][8];
						r_next.rdata[9:8] = silo_mem[r_reg.rp][10:9];
						r_next.rdata[7:0] = silo_mem[r_reg.rp][7:0];
						r_next.rp = r_reg.rp + 6'h01;
					end
				mux_pkg::IDX_LINE_EN:
					r_next.rdata[3:0] = r_reg.line_en;
				default:
					r_next.rdata = 16'h0000;
			endcase
		end
		if (rd_silo)
		begin
			r_next.alarm_cnt = 5'h00;
			r_next.sa = 1'b0;
		end
		// an entry arriving with the access still counts, so the count restarts at one
		if (silo_push)
		begin
			r_next.wp = r_reg.wp + 6'h01;
			if (r_next.alarm_cnt != mux_pkg::ALARM_COUNT)
				r_next.alarm_cnt = r_next.alarm_cnt + 5'h01;
			if (r_next.alarm_cnt == mux_pkg::ALARM_COUNT)
				r_next.sa = 1'b1;
		end
		r_next.fill = r_reg.fill + {6'h00, silo_push} -
			{6'h00, rd_silo && receive_done_flag};
		// vector presented on acknowledge; receive goes first
		if (irq_ack_i)
		begin
			r_next.vec = BASE_VECTOR;
			if (!rx_irq)
				r_next.vec[mux_pkg::VEC_TX_BIT] = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			r_reg <= '0;
			r_reg.tx_out <= 4'hf;
		end
		else
			r_reg <= r_next;
	end

	// silo storage has no reset; fill count guards it
	always_ff @(posedge clk_i)
	begin
		if (silo_push)
			silo_mem[r_reg.wp] <= buf_out_data;
	end
endmodule // serial_mux

//--- verif/serial_mux_asserts.sv
// assertion checker bound to the serial multiplexer top module
`timescale 1ns/100ps
module serial_mux_chk #(
	parameter int CLK_HZ = mux_pkg::CLK_HZ,
	parameter logic [8:0] BASE_VECTOR = mux_pkg::BASE_VECTOR
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] host_idx_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [15:0] host_wdata_i,
	input wire logic [15:0] host_rdata_o,
	input wire logic irq_req_o,
	input wire logic irq_ack_i,
	input wire logic [8:0] irq_vector_o,
	input wire logic [3:0] rx_line_i,
	input wire logic [3:0] tx_line_o
);
	// shadow copies of the enables and per-line formats written by the host
	logic rie_reg;
	logic tie_reg;
	logic [3:0] en_reg;
	logic [3:0][3:0] fmt_reg;
	logic [1:0] len_w;
	logic par_w;
	assign len_w = fmt_reg[host_rdata_o[9:8]][1:0];
	assign par_w = fmt_reg[host_rdata_o[9:8]][3];
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rie_reg <= 1'b0;
			tie_reg <= 1'b0;
			en_reg <= 4'h0;
			fmt_reg <= '0;
		end
		else if (host_wr_i)
		begin
			if (host_idx_i == mux_pkg::IDX_CONTROL)
			begin
				rie_reg <= host_wdata_i[mux_pkg::CF_RIE];
				tie_reg <= host_wdata_i[mux_pkg::CF_TIE];
			end
			if (host_idx_i == mux_pkg::IDX_LINE_EN)
				en_reg <= host_wdata_i[3:0];
			if (host_idx_i == mux_pkg::IDX_SILO)
				fmt_reg[host_wdata_i[1:0]] <= host_wdata_i[6:3];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	AST_VEC_ALIGNED: assert property (irq_ack_i |=>
		irq_vector_o[1:0] == 2'h0 && irq_vector_o[8:3] == BASE_VECTOR[8:3])
		else $error("vector base bits wrong");
	AST_VEC_HOLDS: assert property (!irq_ack_i |=> $stable(irq_vector_o))
		else $error("vector changed without acknowledge");
	AST_TX_VECTOR: assert property (irq_req_o && irq_ack_i && tie_reg
		&& !rie_reg |=> irq_vector_o == (BASE_VECTOR | 9'h004))
		else $error("transmit vector wrong");
	AST_RX_VECTOR: assert property (irq_req_o && irq_ack_i && !tie_reg
		|=> irq_vector_o == BASE_VECTOR)
		else $error("receive vector wrong");
	AST_NO_RX_IRQ: assert property (!rie_reg && !tie_reg |-> !irq_req_o)
		else $error("interrupt with all enables clear");
	AST_SHORT_ZERO: assert property (host_rd_i && host_idx_i ==
		mux_pkg::IDX_SILO |=> !host_rdata_o[15] ||
		(host_rdata_o[7:0] & (8'hff << (4'd5 + {2'b00, len_w}))) == 8'h00)
		else $error("upper data bits not zero");
	AST_NO_PERR: assert property (host_rd_i && host_idx_i ==
		mux_pkg::IDX_SILO |=> !host_rdata_o[15] || par_w || !host_rdata_o[12])
		else $error("parity error without parity");
	AST_READY_LINE: assert property (host_rd_i && host_idx_i ==
		mux_pkg::IDX_CONTROL |=> !host_rdata_o[15] || en_reg[host_rdata_o[9:8]])
		else $error("ready for a disabled line");
	AST_RDATA_PULSE: assert property (!host_rd_i |=> host_rdata_o == 16'h0000)
		else $error("read data outside read cycle");
endmodule // serial_mux_chk
bind serial_mux serial_mux_chk #(
	.CLK_HZ(CLK_HZ),
	.BASE_VECTOR(BASE_VECTOR)
) chk_u (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.host_idx_i(host_idx_i),
	.host_wr_i(host_wr_i),
	.host_rd_i(host_rd_i),
	.host_wdata_i(host_wdata_i),
	.host_rdata_o(host_rdata_o),
	.irq_req_o(irq_req_o),
	.irq_ack_i(irq_ack_i),
	.irq_vector_o(irq_vector_o),
	.rx_line_i(rx_line_i),
	.tx_line_o(tx_line_o)
);

//--- verif/serial_peer.sv
// serial terminal model facing the four multiplexer lines
`timescale 1ns/100ps
module serial_peer #(
	parameter int BIT = 160
) (
	input wire logic clk_i,
	output logic [3:0] rx_line_o,
	input wire logic [3:0] tx_line_i
);
	// idle lines rest at mark, as a real terminal holds them
	initial rx_line_o = 4'hf;
	task automatic send(input logic [1:0] ln, input logic [7:0] d,
		input int nb, input logic par, input logic odd, input logic bad);
		logic p;
		p = ^(d & ~(8'hff << nb)) ^ odd ^ bad;
		@(posedge clk_i);
		rx_line_o[ln] <= 1'b0;
		repeat (BIT) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			rx_line_o[ln] <= d[i];
			repeat (BIT) @(posedge clk_i);
		end
		if (par)
		begin
			rx_line_o[ln] <= p;
			repeat (BIT) @(posedge clk_i);
		end
		rx_line_o[ln] <= 1'b1;
		repeat (BIT) @(posedge clk_i);
	endtask
	task automatic recv(input logic [1:0] ln, input int nb, input logic par,
		input logic odd, output logic [7:0] d, output logic ok);
		d = 8'h00;
		for (int n = 0; n < 40 * BIT && tx_line_i[ln] !== 1'b0; n++)
			@(posedge clk_i);
		repeat (BIT / 2) @(posedge clk_i);
		ok = (tx_line_i[ln] === 1'b0);
		for (int i = 0; i < nb; i++)
		begin
			repeat (BIT) @(posedge clk_i);
			d[i] = tx_line_i[ln];
		end
		if (par)
		begin
			repeat (BIT) @(posedge clk_i);
			ok = ok && (tx_line_i[ln] === (^d ^ odd));
		end
		repeat (BIT) @(posedge clk_i);
		ok = ok && (tx_line_i[ln] === 1'b1);
	endtask
endmodule // serial_peer

//--- verif/tb.sv
// self-checking testbench for the serial multiplexer
`timescale 1ns/100ps
`define CHECK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("[ERR] %0t got %h exp %h", $time, got, exp); \
		end \
	end
module tb;
	// shortened clock so that the 50 baud code gives a 10-cycle tick
	localparam int CLK_HZ = 8000;
	localparam int BIT = 16 * (CLK_HZ / 800);
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] host_idx_i = 2'h0;
	logic host_wr_i = 1'b0;
	logic host_rd_i = 1'b0;
	logic [15:0] host_wdata_i = 16'h0000;
	logic [15:0] host_rdata_o;
	logic irq_req_o;
	logic irq_ack_i = 1'b0;
	logic [8:0] irq_vector_o;
	logic [3:0] rx_line;
	logic [3:0] tx_line;
	int mismatches = 0;
	int n_tests = 0;
	always #20 clk_i = ~clk_i;
	serial_mux #(
		.CLK_HZ(CLK_HZ),
		.BASE_VECTOR(mux_pkg::BASE_VECTOR) // low three bits zero
	) dut_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.host_idx_i(host_idx_i),
		.host_wr_i(host_wr_i),
		.host_rd_i(host_rd_i),
		.host_wdata_i(host_wdata_i),
		.host_rdata_o(host_rdata_o),
		.irq_req_o(irq_req_o),
		.irq_ack_i(irq_ack_i),
		.irq_vector_o(irq_vector_o),
		.rx_line_i(rx_line),
		.tx_line_o(tx_line)
	);
	serial_peer #(.BIT(BIT)) peer_u (
		.clk_i(clk_i),
		.rx_line_o(rx_line),
		.tx_line_i(tx_line)
	);
	function automatic logic [15:0] fmt(logic [1:0] ln, logic [1:0] len,
		logic par, logic odd, logic rxe);
		return {3'h0, rxe, 4'h0, odd, par, 1'b0, len, 1'b0, ln};
	endfunction
	task automatic wr(input logic [1:0] idx, input logic [15:0] d);
		@(posedge clk_i);
		host_idx_i <= idx;
		host_wdata_i <= d;
		host_wr_i <= 1'b1;
		@(posedge clk_i);
		host_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] idx, output logic [15:0] d);
		@(posedge clk_i);
		host_idx_i <= idx;
		host_rd_i <= 1'b1;
		@(posedge clk_i);
		host_rd_i <= 1'b0;
		#1;
		d = host_rdata_o;
	endtask
	task automatic ack(output logic [8:0] v);
		@(posedge clk_i);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		#1;
		v = irq_vector_o;
	endtask
	task automatic wait_irq();
		for (int n = 0; n < 200 && irq_req_o !== 1'b1; n++)
		begin
			@(posedge clk_i);
			#1;
		end
		// a wait that runs out is a failure in its own right
		`CHECK(irq_req_o, 1'b1)
	endtask
	task automatic t_format();
		// each entry: corrupt parity, odd, parity enable, length code
		logic [4:0] cfg [6] = '{5'b01000, 5'b01101, 5'b00110, 5'b00011,
			5'b11111, 5'b10100};
		logic [15:0] d;
		logic [7:0] m;
		logic [4:0] c;
		for (int k = 0; k < 6; k++)
		begin
			c = cfg[k];
			wr(mux_pkg::IDX_SILO, fmt(2'h0, c[1:0], c[2], c[3], 1'b1));
			peer_u.send(2'h0, 8'hb5, 5 + c[1:0], c[2], c[3], c[4]);
			repeat (20) @(posedge clk_i);
			rd(mux_pkg::IDX_CONTROL, d);
			`CHECK(d[mux_pkg::CF_RECEIVE_DONE_FLAG], 1'b1)
			rd(mux_pkg::IDX_SILO, d);
			m = 8'hb5 & ~(8'hff << (5 + c[1:0]));
			`CHECK(d, {1'b1, 2'b00, c[4], 4'h0, m})
			rd(mux_pkg::IDX_CONTROL, d);
			`CHECK(d[mux_pkg::CF_RECEIVE_DONE_FLAG], 1'b0)
		end
		wr(mux_pkg::IDX_SILO, fmt(2'h0, 2'h3, 1'b0, 1'b0, 1'b0));
		peer_u.send(2'h0, 8'h81, 8, 1'b0, 1'b0, 1'b0);
		repeat (20) @(posedge clk_i);
		rd(mux_pkg::IDX_SILO, d);
		`CHECK(d, 16'h0000)
	endtask
	task automatic t_rx_irq();
		logic [15:0] d;
		logic [8:0] v;
		wr(mux_pkg::IDX_SILO, fmt(2'h0, 2'h3, 1'b0, 1'b0, 1'b1));
		wr(mux_pkg::IDX_CONTROL, 16'h0040);
		peer_u.send(2'h0, 8'h3c, 8, 1'b0, 1'b0, 1'b0);
		peer_u.send(2'h0, 8'hc3, 8, 1'b0, 1'b0, 1'b0);
		wait_irq();
		ack(v);
		`CHECK(v, mux_pkg::BASE_VECTOR)
		rd(mux_pkg::IDX_SILO, d);
		`CHECK(d, 16'h803c)
		`CHECK(irq_req_o, 1'b1)
		repeat (25) @(posedge clk_i);
		rd(mux_pkg::IDX_SILO, d);
		`CHECK(irq_req_o, 1'b0)
		peer_u.send(2'h0, 8'h5a, 8, 1'b0, 1'b0, 1'b0);
		wr(mux_pkg::IDX_CONTROL, 16'h0000);
		`CHECK(irq_req_o, 1'b0)
		rd(mux_pkg::IDX_CONTROL, d);
		`CHECK(d[mux_pkg::CF_RECEIVE_DONE_FLAG], 1'b1)
		rd(mux_pkg::IDX_SILO, d);
	endtask
	task automatic t_alarm();
		logic [15:0] d;
		wr(mux_pkg::IDX_CONTROL, 16'h1040);
		for (int k = 0; k < 16; k++)
		begin
			if (k == 15)
				`CHECK(irq_req_o, 1'b0)
			peer_u.send(2'h0, 8'(k), 8, 1'b0, 1'b0, 1'b0);
		end
		wait_irq();
		rd(mux_pkg::IDX_CONTROL, d);
		`CHECK(d[mux_pkg::CF_SA], 1'b1)
		for (int k = 0; k < 17; k++)
		begin
			repeat (25) @(posedge clk_i);
			rd(mux_pkg::IDX_SILO, d);
			`CHECK(d, (k < 16) ? 16'h8000 | 16'(k) : 16'h0000)
			if (k == 0)
				`CHECK(irq_req_o, 1'b0)
		end
	endtask
	task automatic t_tx();
		logic [15:0] d;
		logic [8:0] v;
		logic [7:0] b;
		logic ok;
		wr(mux_pkg::IDX_SILO, fmt(2'h3, 2'h0, 1'b1, 1'b1, 1'b0));
		wr(mux_pkg::IDX_LINE_EN, 16'h000a);
		repeat (20) @(posedge clk_i);
		rd(mux_pkg::IDX_CONTROL, d);
		`CHECK(d[15], 1'b1)
		`CHECK(d[9:8], 2'h3)
		wr(mux_pkg::IDX_CONTROL, 16'h4000);
		wait_irq();
		ack(v);
		`CHECK(v, mux_pkg::BASE_VECTOR | 9'h004)
		wr(mux_pkg::IDX_HOLD, 16'h0015);
		peer_u.recv(2'h3, 5, 1'b1, 1'b1, b, ok);
		`CHECK(b, 8'h15)
		`CHECK(ok, 1'b1)
		peer_u.send(2'h0, 8'h66, 8, 1'b0, 1'b0, 1'b0);
		wr(mux_pkg::IDX_CONTROL, 16'h4040);
		wait_irq();
		ack(v);
		`CHECK(v, mux_pkg::BASE_VECTOR)
		rd(mux_pkg::IDX_SILO, d);
		wait_irq();
		ack(v);
		`CHECK(v, mux_pkg::BASE_VECTOR | 9'h004)
		wr(mux_pkg::IDX_CONTROL, 16'h0000);
		wr(mux_pkg::IDX_LINE_EN, 16'h0000);
		`CHECK(irq_req_o, 1'b0)
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_format();
		t_rx_irq();
		t_alarm();
		t_tx();
		report_and_stop();
	end
endmodule // tb
